//--- common/ermon_pkg.sv
// Shared constants and carrier types for the early-response ordering and exclusive monitor bridge.
// Assumes a single bus clock; every user writes ermon_pkg::name, nothing is imported.
package ermon_pkg;

    // ==========================================================
    // Widths and sizes.
    localparam int ADDR_W = 32;
    localparam int ID_W = 2;
    localparam int NUM_ID = 4;
    localparam int DATA_W = 64;
    localparam int STRB_W = DATA_W / 8;
    localparam int CACHE_W = 4;
    localparam int DEPTH = 4;
    localparam int PTR_W = 2;
    // Single-copy atomic granule is 8 bytes, so overlap is judged on address bits above bit 2.
    localparam int ATOM_LG = 3;
    localparam int GR_W = ADDR_W - ATOM_LG;
    // Address bits at and above this one select the downstream slave.
    localparam int SLV_LSB = 16;

    // ==========================================================
    // Field positions and encodings.
    localparam int CACHE_BUF_BIT = 0;
    localparam logic [2:0] CACHE_DEV = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_EXOKAY = 2'h1;
    localparam logic LOCK_NORMAL = 1'h0;
    localparam logic LOCK_EXCL = 1'h1;

    // ==========================================================
    // Carriers.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [ID_W-1:0] id;
        logic [CACHE_W-1:0] cache;
        logic lock;
        logic [DATA_W-1:0] data;
        logic [STRB_W-1:0] strb;
    } ermon_req_t;

    typedef struct packed {
        logic wr;
        logic early;
        logic excl;
        logic dev;
        logic atom;
        logic [ID_W-1:0] id;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [STRB_W-1:0] strb;
    } ermon_ent_t;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic [1:0] resp;
        logic [DATA_W-1:0] data;
    } ermon_rsp_t;

    typedef struct packed {
        logic [1:0] resp;
        logic [DATA_W-1:0] data;
    } ermon_dsr_t;

    typedef struct packed {
        ermon_ent_t [DEPTH-1:0] q;
        logic [DEPTH-1:0] qv;
        logic [DEPTH-1:0] qi;
        logic [PTR_W-1:0] head;
        logic [PTR_W-1:0] iss;
        logic [PTR_W-1:0] tail;
        logic b_valid;
        ermon_rsp_t b;
        logic r_valid;
        ermon_rsp_t r;
        logic [NUM_ID-1:0] mon_v;
        logic [NUM_ID-1:0][GR_W-1:0] mon_a;
    } ermon_state_t;

endpackage

//--- design/ermon_bridge.sv
// Intermediate bridge that may answer writes early, keeps ordering and atomicity, and monitors exclusives.
// Assumes upstream requests are single-beat and the downstream port answers in issue order.
// Rules the bridge and its masters work under
// R1: Keep an early-answered transaction visible to every later upstream transaction.
// R2: Later transactions overlapping an early-answered one must observe it.
// R3: Device same-ID same-slave transactions stay behind an early-answered one.
// R4: Answer early only when the cache attributes allow it, else wait downstream.
// R5: Overlapping Device transactions stay ordered whatever their IDs.
// R6: Device needs ordering for same ID always, different ID only on overlap.
// R7: Normal needs ordering only on overlap, even with a shared ID.
// R8: Cache bits three to one not all zero means Normal memory.
// R9: Ordered write observation is a true/false property, false by default.
// R10: Declare ordered write observation only if same-ID writes are seen in order.
// R11: Without it, masters wait for a write answer before touching another peripheral.
// R12: Larger transactions update memory in blocks of at least the atomic size.
// R13: No master may see a partly updated atomic element.
// R14: Atomicity never exceeds start address alignment.
// R15: Byte strobes do not change the atomicity size.
// R16: All agents see writes to one location in one order.
// R17: A single serialization point orders each address.
// R18: No forwarding buffer lets some agents see a write before others.
// R19: Lock selects exclusive; read and write answers report its outcome.
// R20: Masters finish an exclusive with a same-address same-ID exclusive write.
// R21: Exclusive write succeeds only if nobody wrote the location since the read.
// R22: One monitored address per ID; a new exclusive read replaces it.
// R23: A successful exclusive read answers EXOKAY.
// R24: A failed exclusive write answers OKAY and leaves memory untouched.
// R25: Lock is one bit: zero normal, one exclusive.
// R26: Stall new transactions whose granule overlaps a pending early-answered one.
`timescale 1ns/1ps
module ermon_bridge #(
    parameter logic OWO_EN = 1'b0 // Ordered write observation declared.
) (
    input wire logic CLK, // Bus clock, 25 MHz.
    input wire logic RST_N, // Asynchronous reset, active low.
    input wire logic S_AW_VALID, // Upstream write request valid.
    output logic S_AW_READY, // Upstream write request taken.
    input wire ermon_pkg::ermon_req_t S_AW, // Upstream write address, control and data.
    input wire logic S_AR_VALID, // Upstream read request valid.
    output logic S_AR_READY, // Upstream read request taken.
    input wire ermon_pkg::ermon_req_t S_AR, // Upstream read address and control.
    output logic S_B_VALID, // Upstream write answer valid.
    input wire logic S_B_READY, // Upstream write answer taken.
    output ermon_pkg::ermon_rsp_t S_B, // Upstream write answer.
    output logic S_R_VALID, // Upstream read answer valid.
    input wire logic S_R_READY, // Upstream read answer taken.
    output ermon_pkg::ermon_rsp_t S_R, // Upstream read answer.
    output logic M_REQ_VALID, // Downstream request valid.
    input wire logic M_REQ_READY, // Downstream request taken.
    output ermon_pkg::ermon_ent_t M_REQ, // Downstream request.
    input wire logic M_RSP_VALID, // Downstream answer valid.
    output logic M_RSP_READY, // Downstream answer taken.
    input wire ermon_pkg::ermon_dsr_t M_RSP, // Downstream answer.
    output logic OWO // Ordered write observation property.
);

    // ==========================================================
    // Helpers.

    // Granule index; strobes play no part, so the atomic size never depends on them.
    function automatic logic [ermon_pkg::GR_W-1:0] gran(input logic [ermon_pkg::ADDR_W-1:0] a);
        gran = a[ermon_pkg::ADDR_W-1:ermon_pkg::ATOM_LG]; // R15
    endfunction

    // Normal when cache bits three to one are not all zero.
    function automatic logic is_dev(input logic [ermon_pkg::CACHE_W-1:0] c);
        is_dev = (c[3:1] == ermon_pkg::CACHE_DEV); // R8
    endfunction

    // True when a new request must wait behind a pending early-answered entry.
    function automatic logic hazard(input ermon_pkg::ermon_state_t s, input ermon_pkg::ermon_req_t n);
        logic h;
        h = 1'b0;
        for (int i = 0; i < ermon_pkg::DEPTH; i++) begin
            if (s.qv[i] && s.q[i].early) begin
                // Overlap orders every memory type regardless of ID.
                if (gran(s.q[i].addr) == gran(n.addr)) begin
                    h = 1'b1; // R2 R5 R7 R26
                end
                // Device also orders same ID to the same slave without overlap.
                if (is_dev(n.cache) && s.q[i].dev && s.q[i].id == n.id
                    && s.q[i].addr[ermon_pkg::ADDR_W-1:ermon_pkg::SLV_LSB]
                    == n.addr[ermon_pkg::ADDR_W-1:ermon_pkg::SLV_LSB]) begin
                    h = 1'b1; // R3 R6
                end
            end
        end
        hazard = h;
    endfunction

    // True when any monitor still watches the granule.
    function automatic logic mon_hits(input ermon_pkg::ermon_state_t s, input logic [ermon_pkg::GR_W-1:0] g);
        logic h;
        h = 1'b0;
        for (int i = 0; i < ermon_pkg::NUM_ID; i++) begin
            if (s.mon_v[i] && s.mon_a[i] == g) begin
                h = 1'b1;
            end
        end
        mon_hits = h;
    endfunction

    // Build a queue entry; atomic guarantee only when the start is granule aligned.
    function automatic ermon_pkg::ermon_ent_t mk_ent(input ermon_pkg::ermon_req_t n, input logic wr);
        ermon_pkg::ermon_ent_t e;
        e.wr = wr;
        e.early = wr && n.cache[ermon_pkg::CACHE_BUF_BIT] && (n.lock == ermon_pkg::LOCK_NORMAL); // R4
        e.excl = (n.lock == ermon_pkg::LOCK_EXCL); // R19 R25
        e.dev = is_dev(n.cache);
        e.atom = (n.addr[ermon_pkg::ATOM_LG-1:0] == '0); // R14
        e.id = n.id;
        e.addr = n.addr;
        e.data = n.data;
        e.strb = n.strb;
        mk_ent = e;
    endfunction

    // ==========================================================
    // State and combinational next value.
    ermon_pkg::ermon_state_t st;
    ermon_pkg::ermon_state_t next_st;
    ermon_pkg::ermon_ent_t he;
    logic hz_w;
    logic hz_r;
    logic aw_pass;
    logic pop;
    logic aw_fire;
    logic ar_fire;

    assign he = st.q[st.head];
    assign hz_w = hazard(st, S_AW);
    assign hz_r = hazard(st, S_AR);
    assign aw_pass = st.mon_v[S_AW.id] && st.mon_a[S_AW.id] == gran(S_AW.addr); // R21

    // Downstream answers for early-answered writes are taken at once; others only when their upstream slot is free.
    assign M_RSP_READY = st.qv[st.head] && st.qi[st.head]
                         && (he.early || (he.wr ? !st.b_valid : !st.r_valid));
    assign pop = M_RSP_VALID && M_RSP_READY;

    // Writes first; both need a free queue slot, only writes also need a free answer slot, and hazards stall.
    assign S_AW_READY = S_AW_VALID && !st.b_valid && !(pop && he.wr && !he.early)
                        && !st.qv[st.tail] && !hz_w; // R1 R26
    assign S_AR_READY = S_AR_VALID && !S_AW_READY && !st.qv[st.tail] && !hz_r; // R1 R18
    assign aw_fire = S_AW_VALID && S_AW_READY;
    assign ar_fire = S_AR_VALID && S_AR_READY;

    // One in-order downstream path is the only serialization point, so every agent sees one write order.
    assign M_REQ_VALID = st.qv[st.iss] && !st.qi[st.iss]; // R16 R17
    assign M_REQ = st.q[st.iss]; // R12 R13
    assign S_B_VALID = st.b_valid;
    assign S_B = st.b;
    assign S_R_VALID = st.r_valid;
    assign S_R = st.r;
    // Writes leave in issue order on one path, which is what makes a true setting legal.
    assign OWO = OWO_EN; // R9 R10

    // Next-state logic: drain answers, retire, issue, then accept.
    always_comb begin
        next_st = st;
        if (S_B_VALID && S_B_READY) begin
            next_st.b_valid = 1'b0;
        end
        if (S_R_VALID && S_R_READY) begin
            next_st.r_valid = 1'b0;
        end
        // Retire the oldest entry; early-answered writes were already reported upstream.
        if (pop) begin
            next_st.qv[st.head] = 1'b0;
            next_st.qi[st.head] = 1'b0;
            next_st.head = st.head + ermon_pkg::PTR_W'(1);
            if (!he.early) begin
                if (he.wr) begin
                    next_st.b_valid = 1'b1;
                    next_st.b.id = he.id;
                    next_st.b.data = '0;
                    next_st.b.resp = (he.excl && M_RSP.resp == ermon_pkg::RESP_OKAY)
                                     ? ermon_pkg::RESP_EXOKAY : M_RSP.resp; // R19
                end else begin
                    next_st.r_valid = 1'b1;
                    next_st.r.id = he.id;
                    next_st.r.data = M_RSP.data;
                    next_st.r.resp = (he.excl && M_RSP.resp == ermon_pkg::RESP_OKAY)
                                     ? ermon_pkg::RESP_EXOKAY : M_RSP.resp; // R23
                end
            end
        end
        if (M_REQ_VALID && M_REQ_READY) begin
            next_st.qi[st.iss] = 1'b1;
            next_st.iss = st.iss + ermon_pkg::PTR_W'(1);
        end
        if (aw_fire) begin
            if (S_AW.lock == ermon_pkg::LOCK_EXCL && !aw_pass) begin
                // Failed exclusive is answered here and never reaches memory.
                next_st.b_valid = 1'b1;
                next_st.b.id = S_AW.id;
                next_st.b.resp = ermon_pkg::RESP_OKAY; // R24
                next_st.b.data = '0;
            end else begin
                next_st.q[st.tail] = mk_ent(S_AW, 1'b1);
                next_st.qv[st.tail] = 1'b1;
                next_st.qi[st.tail] = 1'b0;
                next_st.tail = st.tail + ermon_pkg::PTR_W'(1);
                if (next_st.q[st.tail].early) begin
                    next_st.b_valid = 1'b1;
                    next_st.b.id = S_AW.id;
                    next_st.b.resp = ermon_pkg::RESP_OKAY; // R4
                    next_st.b.data = '0;
                end
                // Any write that goes ahead ends every watch on its granule.
                for (int i = 0; i < ermon_pkg::NUM_ID; i++) begin
                    if (st.mon_a[i] == gran(S_AW.addr)) begin
                        next_st.mon_v[i] = 1'b0; // R21
                    end
                end
            end
        end else if (ar_fire) begin
            next_st.q[st.tail] = mk_ent(S_AR, 1'b0);
            next_st.qv[st.tail] = 1'b1;
            next_st.qi[st.tail] = 1'b0;
            next_st.tail = st.tail + ermon_pkg::PTR_W'(1);
            // An exclusive read replaces whatever this ID watched before.
            if (S_AR.lock == ermon_pkg::LOCK_EXCL) begin
                next_st.mon_v[S_AR.id] = 1'b1; // R22
                next_st.mon_a[S_AR.id] = gran(S_AR.addr); // R22
            end
        end
    end

    // State register; reset empties the queue and drops every watch.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Checks.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence early_acc_s;
        aw_fire && S_AW.cache[ermon_pkg::CACHE_BUF_BIT] && S_AW.lock == ermon_pkg::LOCK_NORMAL;
    endsequence
    sequence excl_fail_s;
        aw_fire && S_AW.lock == ermon_pkg::LOCK_EXCL && !aw_pass;
    endsequence
    sequence excl_rd_ok_s;
        pop && !he.wr && he.excl && M_RSP.resp == ermon_pkg::RESP_OKAY;
    endsequence

    early_resp_a: assert property (early_acc_s |=> S_B_VALID && S_B.id == $past(S_AW.id)) // R4
        else $error("early write not answered");
    // A failed exclusive is answered at once and never goes downstream, so it is left out here.
    late_resp_a: assert property (aw_fire && !(S_AW.lock == ermon_pkg::LOCK_EXCL && !aw_pass) // R4
                                  && !(S_AW.cache[ermon_pkg::CACHE_BUF_BIT] && S_AW.lock == ermon_pkg::LOCK_NORMAL)
                                  |=> !S_B_VALID)
        else $error("write answered early without permission");
    write_stall_a: assert property (S_AW_VALID && hz_w |-> !S_AW_READY) // R26
        else $error("write passed a pending overlap");
    read_stall_a: assert property (S_AR_VALID && hz_r |-> !S_AR_READY) // R2
        else $error("read passed a pending overlap");
    excl_fail_a: assert property (excl_fail_s |=> S_B_VALID && S_B.resp == ermon_pkg::RESP_OKAY
                                  && st.tail == $past(st.tail)) // R24
        else $error("failed exclusive forwarded or misreported");
    excl_watch_a: assert property (ar_fire && S_AR.lock == ermon_pkg::LOCK_EXCL |=> st.mon_v[$past(S_AR.id)]
                                   && st.mon_a[$past(S_AR.id)] == gran($past(S_AR.addr))) // R22
        else $error("exclusive read not monitored");
    mon_clear_a: assert property (aw_fire && !(S_AW.lock == ermon_pkg::LOCK_EXCL && !aw_pass)
                                  |=> !mon_hits(st, gran($past(S_AW.addr)))) // R21
        else $error("monitor survived a write");
    exok_read_a: assert property (excl_rd_ok_s |=> S_R_VALID && S_R.resp == ermon_pkg::RESP_EXOKAY) // R23
        else $error("exclusive read not EXOKAY");
    ds_hold_a: assert property (M_REQ_VALID && !M_REQ_READY |=> M_REQ_VALID && $stable(M_REQ)) // R16
        else $error("downstream request changed while waiting");
    atom_flag_a: assert property (M_REQ_VALID |-> M_REQ.atom == (M_REQ.addr[ermon_pkg::ATOM_LG-1:0] == '0)) // R14
        else $error("atomic flag disagrees with alignment");

endmodule

//--- testbench/ermon_bridge_bench.sv
// Self-checking bench for the early-answer bridge with its exclusive monitor.
// Assumes the behavioural slave below the bridge; answers are always accepted at once.
`timescale 1ns/1ps
module ermon_bridge_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic aw_valid = 1'b0;
    logic ar_valid = 1'b0;
    ermon_pkg::ermon_req_t aw = '0;
    ermon_pkg::ermon_req_t ar = '0;
    logic aw_ready, ar_ready, b_valid, r_valid, owo;
    logic q_valid, q_ready, p_valid, p_ready;
    ermon_pkg::ermon_rsp_t b, r;
    ermon_pkg::ermon_ent_t q;
    ermon_pkg::ermon_dsr_t p;
    int bad_count = 0;
    int num_checks = 0;
    logic [1:0] rs;
    logic [63:0] rd;
    int lat;

    always #20 clk = ~clk;

    ermon_bridge i_dut (.CLK(clk), .RST_N(rst_n), .S_AW_VALID(aw_valid), .S_AW_READY(aw_ready), .S_AW(aw),
        .S_AR_VALID(ar_valid), .S_AR_READY(ar_ready), .S_AR(ar), .S_B_VALID(b_valid), .S_B_READY(1'b1),
        .S_B(b), .S_R_VALID(r_valid), .S_R_READY(1'b1), .S_R(r), .M_REQ_VALID(q_valid),
        .M_REQ_READY(q_ready), .M_REQ(q), .M_RSP_VALID(p_valid), .M_RSP_READY(p_ready), .M_RSP(p), .OWO(owo));

    ermon_far_slave i_far (.CLK(clk), .RST_N(rst_n), .M_REQ_VALID(q_valid), .M_REQ_READY(q_ready),
        .M_REQ(q), .M_RSP_VALID(p_valid), .M_RSP_READY(p_ready), .M_RSP(p));

    // ==========================================================
    // Verdict and comparisons.
    task automatic give_verdict();
        if (bad_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cmp_data(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp_data({62'h0, got}, {62'h0, exp});
    endtask

    // Waits on a level for at most 50 cycles; a hang ends the run as a failure.
    task automatic wait_hi(ref logic sig, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sig !== 1'b1 && n < 50);
        if (sig !== 1'b1) begin
            bad_count++;
            give_verdict();
        end
    endtask

    // ==========================================================
    // Single-beat bus cycles; the request holds until the ready edge.
    task automatic do_write(input logic [31:0] a, input logic [1:0] id, input logic [3:0] c, input logic lk,
                            input logic [63:0] d);
        @(posedge clk);
        #1;
        aw = '{addr: a, id: id, cache: c, lock: lk, data: d, strb: 8'hFF};
        aw_valid = 1'b1;
        wait_hi(aw_ready, lat);
        #1;
        aw_valid = 1'b0;
        wait_hi(b_valid, lat);
        rs = b.resp;
        cmp_resp(b.id, id);
    endtask

    task automatic do_read(input logic [31:0] a, input logic [1:0] id, input logic [3:0] c, input logic lk);
        @(posedge clk);
        #1;
        ar = '{addr: a, id: id, cache: c, lock: lk, data: 64'h0000_0000_0000_0000, strb: 8'h00};
        ar_valid = 1'b1;
        wait_hi(ar_ready, lat);
        #1;
        ar_valid = 1'b0;
        wait_hi(r_valid, lat);
        rs = r.resp;
        rd = r.data;
        cmp_resp(r.id, id);
    endtask

    // ==========================================================
    // Scenarios.
    task automatic test_early();
        do_write(32'h0000_0100, 2'h0, 4'h3, 1'b0, 64'hA5A5_0001_0002_0003);
        cmp_data(64'(lat), 64'h1);
        cmp_resp(rs, ermon_pkg::RESP_OKAY);
        // The read overlaps the still-pending early write and must see it.
        do_read(32'h0000_0104, 2'h1, 4'h2, 1'b0);
        cmp_data(rd, 64'hA5A5_0001_0002_0003);
        cmp_resp(rs, ermon_pkg::RESP_OKAY);
    endtask

    task automatic test_no_early();
        do_write(32'h0000_0200, 2'h0, 4'h2, 1'b0, 64'h1111_2222_3333_4444);
        cmp_data(64'(lat > 1), 64'h1);
        do_write(32'h0000_0208, 2'h0, 4'h0, 1'b0, 64'h5555_6666_7777_8888);
        cmp_data(64'(lat > 1), 64'h1);
    endtask

    task automatic test_device_order();
        do_write(32'h0001_0000, 2'h1, 4'h1, 1'b0, 64'h0BAD_0000_0000_0001);
        do_write(32'h0001_0000, 2'h2, 4'h1, 1'b0, 64'h0BAD_0000_0000_0002);
        do_write(32'h0001_0008, 2'h2, 4'h1, 1'b0, 64'h0BAD_0000_0000_0003);
        do_read(32'h0001_0000, 2'h3, 4'h0, 1'b0);
        cmp_data(rd, 64'h0BAD_0000_0000_0002);
        do_read(32'h0001_0008, 2'h2, 4'h0, 1'b0);
        cmp_data(rd, 64'h0BAD_0000_0000_0003);
    endtask

    task automatic test_excl();
        do_read(32'h0000_0300, 2'h2, 4'h0, 1'b1);
        cmp_resp(rs, ermon_pkg::RESP_EXOKAY);
        do_write(32'h0000_0300, 2'h2, 4'h0, 1'b1, 64'hCAFE_0000_0000_0001);
        cmp_resp(rs, ermon_pkg::RESP_EXOKAY);
        // Another master writes the granule between the exclusive pair.
        do_read(32'h0000_0300, 2'h2, 4'h0, 1'b1);
        do_write(32'h0000_0304, 2'h1, 4'h2, 1'b0, 64'hCAFE_0000_0000_0002);
        do_write(32'h0000_0300, 2'h2, 4'h0, 1'b1, 64'hCAFE_0000_0000_0003);
        cmp_resp(rs, ermon_pkg::RESP_OKAY);
        do_read(32'h0000_0300, 2'h0, 4'h0, 1'b0);
        cmp_data(rd, 64'hCAFE_0000_0000_0002);
    endtask

    task automatic test_excl_replace();
        do_read(32'h0000_0400, 2'h3, 4'h0, 1'b1);
        cmp_resp(rs, ermon_pkg::RESP_EXOKAY);
        do_read(32'h0000_0500, 2'h3, 4'h0, 1'b1);
        do_write(32'h0000_0400, 2'h3, 4'h0, 1'b1, 64'hDEAD_0000_0000_0001);
        cmp_resp(rs, ermon_pkg::RESP_OKAY);
        do_read(32'h0000_0400, 2'h0, 4'h0, 1'b0);
        cmp_data(rd, 64'h0000_0000_0000_0000);
    endtask

    // ==========================================================
    // Main sequence.
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        cmp_data({63'h0, owo}, 64'h0);
        test_early();
        test_no_early();
        test_device_order();
        test_excl();
        test_excl_replace();
        give_verdict();
    end
endmodule

//--- testbench/ermon_far_slave.sv
// Behavioural downstream slave: a small memory answering bridge requests in order.
// Assumes one request and one answer per beat, keyed by 8-byte granule.
`timescale 1ns/1ps
module ermon_far_slave #(
    parameter int LAT = 3 // Cycles from request to answer.
) (
    input wire logic CLK, // Bus clock.
    input wire logic RST_N, // Asynchronous reset, active low.
    input wire logic M_REQ_VALID, // Request from the bridge.
    output logic M_REQ_READY, // Request taken.
    input wire ermon_pkg::ermon_ent_t M_REQ, // Request contents.
    output logic M_RSP_VALID, // Answer valid.
    input wire logic M_RSP_READY, // Answer taken.
    output ermon_pkg::ermon_dsr_t M_RSP // Answer contents.
);
    logic [63:0] mem [logic [28:0]];
    logic [63:0] pend_q [$];
    logic [63:0] cur;
    logic rsp_on;
    int wait_cnt;
    // ==========================================================
    // Memory and in-order answers; a released answer shows inverted data so stale values never match.
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pend_q.delete();
            wait_cnt = 0;
            M_REQ_READY <= 1'b0;
            M_RSP_VALID <= 1'b0;
            M_RSP <= '0;
        end else begin
            rsp_on = M_RSP_VALID;
            if (M_RSP_VALID && M_RSP_READY) begin
                pend_q.delete(0);
                rsp_on = 1'b0;
                M_RSP_VALID <= 1'b0;
                M_RSP <= ~M_RSP;
            end
            if (M_REQ_VALID && M_REQ_READY) begin
                cur = mem.exists(M_REQ.addr[31:3]) ? mem[M_REQ.addr[31:3]] : 64'h0000_0000_0000_0000;
                if (M_REQ.wr) begin
                    for (int i = 0; i < 8; i++) begin
                        if (M_REQ.strb[i]) begin
                            cur[8*i+:8] = M_REQ.data[8*i+:8];
                        end
                    end
                    // The whole granule changes in one step, never half at a time.
                    mem[M_REQ.addr[31:3]] = cur;
                end
                pend_q.push_back(M_REQ.wr ? 64'h0000_0000_0000_0000 : cur);
            end
            if (!rsp_on && pend_q.size() > 0) begin
                wait_cnt++;
                if (wait_cnt >= LAT) begin
                    wait_cnt = 0;
                    M_RSP_VALID <= 1'b1;
                    M_RSP <= '{resp: ermon_pkg::RESP_OKAY, data: pend_q[0]};
                end
            end
            M_REQ_READY <= (pend_q.size() < 4);
        end
    end
endmodule
